// ### bench/mdio_host_model.sv
// Management controller model: drives mdc and host data, samples read data.
// Assumes the bench resolves the shared data wire, pull-up when nobody drives.
`timescale 1ns/1ps
module mdio_host_model (
  input wire logic clk,
  output logic mdc,
  output logic host_oe,
  output logic host_d,
  input wire logic mdio,
  output logic rd_valid,
  output logic [15:0] rd_data
);
  // Clock stands low and the wire is released between frames
  initial begin
    mdc = 1'b0;
    host_oe = 1'b0;
    host_d = 1'b0;
    rd_valid = 1'b0;
    rd_data = 16'h0000;
  end

  // One mdc period of ten clk; data changes while mdc is low
  task automatic bit_io(input logic oe, input logic d, output logic s);
    mdc = 1'b0;
    host_oe = oe;
    host_d = d;
    repeat (5) @(negedge clk);
    mdc = 1'b1;
    s = mdio;
    repeat (5) @(negedge clk);
  endtask : bit_io

  // Whole frame with its own preamble; a read releases the wire from turnaround
  task automatic frame(input logic [4:0] phy, input logic rd, input logic [4:0] ra,
                       input logic [15:0] wd);
    logic s;
    logic [31:0] hdr;
    logic [15:0] r;
    hdr = {18'h3_ffff, 2'b01, rd ? 2'b10 : 2'b01, phy, ra};
    r = 16'h0000;
    // Full run of 32 ones; the bank drops frames with a shorter preamble
    for (int i = 0; i < 32; i++) bit_io(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_io(1'b1, hdr[i], s);
    bit_io(!rd, 1'b1, s);
    bit_io(!rd, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      bit_io(!rd, wd[i], s);
      r = {r[14:0], s};
    end
    mdc = 1'b0;
    host_oe = 1'b0;
    if (rd) begin
      rd_data = r;
      rd_valid = 1'b1;
    end
    // One idle cycle so the next frame never retakes the wire in the same step
    @(negedge clk);
    rd_valid = 1'b0;
  endtask : frame
endmodule : mdio_host_model

// ### bench/test_phy_gig_mgmt_regs.sv
// Self-checking bench for the gigabit management register bank.
// Assumes the host model above and a pulled-up shared data line.
`timescale 1ns/1ps
module test_phy_gig_mgmt_regs;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic mdc, host_oe, host_d, mdio_o, mdio_oe, rd_valid;
  logic manual_config_en, manual_config_master;
  logic [15:0] rd_data;
  wire logic mdio_w = mdio_oe ? mdio_o : (host_oe ? host_d : 1'b1);
  phy_mgmt_pkg::line_status_t ls = '0;
  int fail_count = 0;
  int tests_run = 0;
  logic [15:0] exp_q[$];
  string name_q[$];
  logic [31:0] seed = 32'h704a_52bc;
  logic [15:0] d [4];
  logic [15:0] sts;

  // 10 MHz clock
  always #50 clk = ~clk;

  phy_gig_mgmt_regs i_phy_gig_mgmt_regs (
    .clk(clk), .resetn(resetn), .mdc(mdc), .mdio_i(mdio_w), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .line_status(ls), .manual_config_en(manual_config_en),
    .manual_config_master(manual_config_master)
  );
  mdio_host_model i_mdio_host_model (
    .clk(clk), .mdc(mdc), .host_oe(host_oe), .host_d(host_d), .mdio(mdio_w),
    .rd_valid(rd_valid), .rd_data(rd_data)
  );

  // Galois-free shift register, fixed seed
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic wr(input logic [4:0] ra, input logic [15:0] v);
    i_mdio_host_model.frame(5'h00, 1'b0, ra, v);
  endtask : wr

  // Note the expectation first, then run the read frame
  task automatic rd(input logic [4:0] ra, input logic [15:0] e, input string nm);
    exp_q.push_back(e);
    name_q.push_back(nm);
    i_mdio_host_model.frame(5'h00, 1'b1, ra, 16'h0000);
  endtask : rd

  // Watcher: oldest note against each returned word
  always @(posedge rd_valid) begin
    if (exp_q.size() == 0) begin
      $display("unexpected read result expected none seen %h", rd_data);
      fail_count++;
    end else begin
      chk(name_q.pop_front(), exp_q.pop_front(), rd_data);
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog well beyond the roughly 37k cycles of traffic
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end

  // Main sequence, inputs changed on falling edges
  initial begin
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    // Reset values and fixed ability word
    rd(5'h0a, 16'h0000, "status reset");
    rd(5'h0d, 16'h0000, "control reset");
    rd(5'h0f, 16'h3000, "ability");
    wr(5'h0f, 16'h0000);
    rd(5'h0f, 16'h3000, "ability after write");
    // Wrong station address: wire stays pulled up
    exp_q.push_back(16'hffff);
    name_q.push_back("foreign address");
    i_mdio_host_model.frame(5'h01, 1'b1, 5'h0f, 16'h0000);
    rd(5'h1f, 16'h0000, "unmapped");
    // Manual role and latched fault
    wr(5'h09, 16'h1800);
    repeat (8) @(negedge clk);
    chk("manual enable", 16'h0001, {15'h0000, manual_config_en});
    chk("manual master", 16'h0001, {15'h0000, manual_config_master});
    rd(5'h09, 16'h1800, "config");
    ls.partner_manual_en = 1'b1;
    ls.partner_manual_master = 1'b1;
    repeat (4) @(negedge clk);
    ls = '0;
    rd(5'h0a, 16'h8000, "fault latched");
    rd(5'h0a, 16'h0000, "fault cleared");
    wr(5'h09, 16'h0000);
    // Random status levels with idle error pulses
    for (int k = 0; k < 3; k++) begin
      seed = lfsr_next(seed);
      @(negedge clk);
      ls = {seed[4:0], 3'b000};
      sts = {1'b0, seed[4:0], 2'b00, 8'h00};
      for (int i = 0; i < seed[10:8] + 1; i++) begin
        @(negedge clk);
        ls.idle_error = 1'b1;
        @(negedge clk);
        ls.idle_error = 1'b0;
      end
      rd(5'h0a, sts | 16'(seed[10:8] + 1), "status with count");
      wr(5'h0a, 16'hffff);
      rd(5'h0a, sts, "status after clear");
    end
    ls = '0;
    // Control reserved bits
    wr(5'h0d, 16'hffff);
    rd(5'h0d, 16'hc01f, "control fields");
    // Indirect access through pointer
    for (int i = 0; i < 4; i++) begin
      seed = lfsr_next(seed);
      d[i] = seed[15:0];
    end
    wr(5'h0d, 16'h001f);
    wr(5'h0e, 16'h0020);
    rd(5'h0e, 16'h0020, "pointer");
    wr(5'h0d, 16'h801f);
    for (int i = 0; i < 4; i++) wr(5'h0e, d[i]);
    wr(5'h0d, 16'h001f);
    rd(5'h0e, 16'h0024, "pointer after writes");
    wr(5'h0e, 16'h0020);
    wr(5'h0d, 16'h401f);
    rd(5'h0e, d[0], "data no increment");
    rd(5'h0e, d[0], "data no increment again");
    wr(5'h0e, d[3]);
    rd(5'h0e, d[3], "data write no increment");
    wr(5'h0d, 16'hc01f);
    rd(5'h0e, d[3], "read no increment");
    rd(5'h0e, d[3], "read no increment again");
    wr(5'h0e, d[0]);
    rd(5'h0e, d[1], "after write increment");
    wr(5'h0d, 16'h801f);
    rd(5'h0e, d[1], "read increment first");
    rd(5'h0e, d[2], "read increment second");
    // Foreign device address ignored
    wr(5'h0d, 16'h801e);
    rd(5'h0e, 16'h0000, "foreign device read");
    wr(5'h0e, 16'hffff);
    wr(5'h0d, 16'h401f);
    rd(5'h0e, d[3], "pointer kept");
    // Unimplemented extended address
    wr(5'h0d, 16'h001f);
    wr(5'h0e, 16'h0100);
    wr(5'h0d, 16'h401f);
    wr(5'h0e, 16'hffff);
    rd(5'h0e, 16'h0000, "unimplemented");
    repeat (10) @(negedge clk);
    chk("pending notes", 16'h0000, 16'(exp_q.size()));
    tally_and_finish();
  end
endmodule : test_phy_gig_mgmt_regs

// ### verilog/ext_reg_store.sv
// Extended register window reached through the indirect pointer.
// Assumes writes come one per cycle from the bank in the same clock domain.
`timescale 1ns/1ps
module ext_reg_store #(
  parameter int DEPTH = phy_mgmt_pkg::EXT_DEPTH,
  parameter logic [15:0] BASE = phy_mgmt_pkg::EXT_BASE
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] rd_addr,
  output logic [15:0] rd_data,
  output logic rd_hit,
  input wire logic wr_en,
  input wire logic [15:0] wr_addr,
  input wire logic [15:0] wr_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Storage words, cleared by reset
  logic [DEPTH-1:0][15:0] mem_q;
  logic [DEPTH-1:0][15:0] mem_d;
  logic [15:0] rd_off;
  logic [15:0] wr_off;
  logic wr_hit;

  // Offsets into the window; anything outside misses
  assign rd_off = rd_addr - BASE;
  assign wr_off = wr_addr - BASE;
  assign rd_hit = (rd_addr >= BASE) && (rd_off < 16'(DEPTH));
  assign wr_hit = (wr_addr >= BASE) && (wr_off < 16'(DEPTH));

  // Missing addresses read zero
  assign rd_data = rd_hit ? mem_q[rd_off[AW-1:0]] : 16'h0000; // see RULE19

  // Write only on a hit; a miss leaves the array alone
  always_comb begin
    mem_d = mem_q;
    if (wr_en && wr_hit) begin // see RULE19
      mem_d[wr_off[AW-1:0]] = wr_data;
    end
  end

  // Register the array
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_q <= '0;
    end else begin
      mem_q <= mem_d;
    end
  end

endmodule : ext_reg_store

// ### verilog/phy_gig_mgmt_regs.sv
// Management serial slave with gigabit status, ability, config and indirect access.
// Assumes the management clock runs at most one eighth of clk, and line status
// inputs come from logic on clk.
`timescale 1ns/1ps
module phy_gig_mgmt_regs #(
  parameter logic [4:0] PHY_ADDR = 5'h00,
  parameter int EXT_DEPTH = phy_mgmt_pkg::EXT_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire phy_mgmt_pkg::line_status_t line_status,
  output logic manual_config_en,
  output logic manual_config_master
);

  // State and its next value
  phy_mgmt_pkg::mgmt_state_t q;
  phy_mgmt_pkg::mgmt_state_t d;

  // Edge of the synchronised management clock
  logic rise;
  // Sampled serial bit
  logic sbit;
  // Header as it would stand after this edge
  logic [13:0] hdr;
  // Header checks
  logic hdr_ok;
  // Read taken this cycle and its word
  logic rd_commit;
  logic [15:0] rd_val;
  // Write taken this cycle and its word
  logic wr_commit;
  logic [15:0] wr_word;
  // Device address matches the vendor space
  logic target_device_address_ok;
  // Manual role conflict seen on the line
  logic fault_now;
  // Extended store ports
  logic [15:0] ext_rd_data;
  logic ext_rd_hit;
  logic ext_we;

  // Function is a data access of any kind
  function automatic logic is_data_fn(input phy_mgmt_pkg::access_fn_t f);
    return f != phy_mgmt_pkg::FN_ADDRESS;
  endfunction : is_data_fn

  // Only the second flop of each synchroniser is looked at
  assign rise = q.mdc_s2 & ~q.mdc_prev;
  assign sbit = q.mdio_s2;
  assign hdr = {q.sh[12:0], sbit};
  assign hdr_ok = (hdr[13:12] == phy_mgmt_pkg::FRAME_START) && (hdr[9:5] == PHY_ADDR)
                  && ((hdr[11:10] == phy_mgmt_pkg::OP_READ)
                      || (hdr[11:10] == phy_mgmt_pkg::OP_WRITE));
  assign target_device_address_ok = (q.target_device_address == phy_mgmt_pkg::VENDOR_DEVICE_ADDR); // see RULE14
  assign wr_word = {q.sh[14:0], sbit};

  // Conflict: both ends forced manual and picked the same role
  assign fault_now = q.manual_en && line_status.partner_manual_en
                     && (q.manual_master == line_status.partner_manual_master); // see RULE18

  // Outputs straight from flops
  assign mdio_o = q.drv_o;
  assign mdio_oe = q.drv_oe;
  assign manual_config_en = q.manual_en; // see RULE18
  assign manual_config_master = q.manual_master; // see RULE18

  // Extended window behind the pointer
  ext_reg_store #(
    .DEPTH(EXT_DEPTH),
    .BASE(phy_mgmt_pkg::EXT_BASE)
  ) u_ext (
    .clk(clk),
    .resetn(resetn),
    .rd_addr(q.ptr),
    .rd_data(ext_rd_data),
    .rd_hit(ext_rd_hit),
    .wr_en(ext_we),
    .wr_addr(q.ptr),
    .wr_data(wr_word)
  );

  // Read word for the addressed register
  always_comb begin
    rd_val = 16'h0000;
    unique case (hdr[4:0])
      phy_mgmt_pkg::REG_GIG_CONFIG: begin
        rd_val[phy_mgmt_pkg::CFG_MANUAL_EN_BIT] = q.manual_en;
        rd_val[phy_mgmt_pkg::CFG_MANUAL_VAL_BIT] = q.manual_master;
      end
      phy_mgmt_pkg::REG_LINK_STATUS: begin
        // Bits 9:8 stay zero; see RULE7
        rd_val = {q.ms_fault, line_status.resolved_master, line_status.local_rx_ok, // see RULE3
                  line_status.remote_rx_ok, line_status.partner_full_duplex, // see RULE4 RULE5
                  line_status.partner_half_duplex, 2'b00, q.idle_cnt}; // see RULE2
      end
      phy_mgmt_pkg::REG_ACCESS_CTRL: begin
        rd_val = {q.fn, 9'h000, q.target_device_address}; // see RULE16
      end
      phy_mgmt_pkg::REG_ADDR_DATA: begin
        // Wrong device address reads zero
        if (!target_device_address_ok) begin
          rd_val = 16'h0000; // see RULE14
        end else if (q.fn == phy_mgmt_pkg::FN_ADDRESS) begin
          rd_val = q.ptr;
        end else begin
          rd_val = ext_rd_data; // see RULE8
        end
      end
      phy_mgmt_pkg::REG_LOCAL_ABILITY: begin
        rd_val = phy_mgmt_pkg::ABILITY_VALUE; // see RULE17 RULE7
      end
      default: begin
        rd_val = 16'h0000;
      end
    endcase
  end

  // Frame engine, register effects and line-side flags
  always_comb begin
    d = q;
    rd_commit = 1'b0;
    wr_commit = 1'b0;
    ext_we = 1'b0;
    // Two-flop synchronisers
    d.mdc_s1 = mdc;
    d.mdc_s2 = q.mdc_s1;
    d.mdc_prev = q.mdc_s2;
    d.mdio_s1 = mdio_i;
    d.mdio_s2 = q.mdio_s1;
    if (rise) begin
      unique case (q.st)
        phy_mgmt_pkg::ST_PREAMBLE: begin
          // Need a full run of ones before the start bit
          if (sbit) begin
            if (q.cnt != phy_mgmt_pkg::PREAMBLE_BITS) begin
              d.cnt = q.cnt + 6'd1;
            end
          end else if (q.cnt == phy_mgmt_pkg::PREAMBLE_BITS) begin
            d.st = phy_mgmt_pkg::ST_HEADER;
            d.sh = 16'h0000;
            d.cnt = 6'd1;
          end else begin
            d.cnt = 6'd0;
          end
        end
        phy_mgmt_pkg::ST_HEADER: begin
          d.sh = {q.sh[14:0], sbit};
          d.cnt = q.cnt + 6'd1;
          if (q.cnt == phy_mgmt_pkg::HEADER_LAST) begin
            d.cnt = 6'd0;
            // Other addresses and bad frames are left alone
            if (hdr_ok) begin
              d.st = phy_mgmt_pkg::ST_TURN;
              d.reg_a = hdr[4:0];
              d.op_read = (hdr[11:10] == phy_mgmt_pkg::OP_READ);
              if (hdr[11:10] == phy_mgmt_pkg::OP_READ) begin
                rd_commit = 1'b1;
                d.sh = rd_val;
              end
            end else begin
              d.st = phy_mgmt_pkg::ST_PREAMBLE;
            end
          end
        end
        phy_mgmt_pkg::ST_TURN: begin
          d.cnt = q.cnt + 6'd1;
          // Second turnaround bit is driven low on reads
          if (q.cnt == 6'd0) begin
            if (q.op_read) begin
              d.drv_oe = 1'b1; // see RULE8
              d.drv_o = 1'b0;
            end
          end else begin
            d.cnt = 6'd0;
            if (q.op_read) begin
              d.st = phy_mgmt_pkg::ST_READ_DATA;
              d.drv_o = q.sh[15];
              d.sh = {q.sh[14:0], 1'b0};
            end else begin
              d.st = phy_mgmt_pkg::ST_WRITE_DATA;
            end
          end
        end
        phy_mgmt_pkg::ST_READ_DATA: begin
          d.cnt = q.cnt + 6'd1;
          if (q.cnt == phy_mgmt_pkg::DATA_LAST) begin
            d.drv_oe = 1'b0;
            d.drv_o = 1'b0;
            d.st = phy_mgmt_pkg::ST_PREAMBLE;
            d.cnt = 6'd0;
          end else begin
            d.drv_o = q.sh[15];
            d.sh = {q.sh[14:0], 1'b0};
          end
        end
        phy_mgmt_pkg::ST_WRITE_DATA: begin
          d.sh = wr_word;
          d.cnt = q.cnt + 6'd1;
          if (q.cnt == phy_mgmt_pkg::DATA_LAST) begin
            wr_commit = 1'b1;
            d.st = phy_mgmt_pkg::ST_PREAMBLE;
            d.cnt = 6'd0;
          end
        end
        default: begin
          // Illegal code: drop the frame
          d.st = phy_mgmt_pkg::ST_PREAMBLE;
          d.cnt = 6'd0;
          d.drv_oe = 1'b0;
        end
      endcase
    end
    // Side effects of a read
    if (rd_commit) begin
      if (hdr[4:0] == phy_mgmt_pkg::REG_LINK_STATUS) begin
        d.ms_fault = 1'b0; // see RULE1
        d.idle_cnt = 8'h00; // see RULE6
      end
      if ((hdr[4:0] == phy_mgmt_pkg::REG_ADDR_DATA) && target_device_address_ok
          && (q.fn == phy_mgmt_pkg::FN_DATA_INC_RW)) begin
        d.ptr = q.ptr + 16'h0001; // see RULE12
      end
    end
    // Effects of a write; read-only registers ignore it
    if (wr_commit) begin
      unique case (q.reg_a)
        phy_mgmt_pkg::REG_GIG_CONFIG: begin
          d.manual_en = wr_word[phy_mgmt_pkg::CFG_MANUAL_EN_BIT]; // see RULE18
          d.manual_master = wr_word[phy_mgmt_pkg::CFG_MANUAL_VAL_BIT];
        end
        phy_mgmt_pkg::REG_ACCESS_CTRL: begin
          // Reserved bits 13:5 dropped
          d.fn = phy_mgmt_pkg::access_fn_t'(wr_word[15:14]); // see RULE16
          d.target_device_address = wr_word[4:0];
        end
        phy_mgmt_pkg::REG_ADDR_DATA: begin
          if (target_device_address_ok) begin // see RULE14
            if (q.fn == phy_mgmt_pkg::FN_ADDRESS) begin
              d.ptr = wr_word; // see RULE9
            end else begin
              ext_we = 1'b1; // see RULE11
              if (q.fn != phy_mgmt_pkg::FN_DATA) begin
                d.ptr = q.ptr + 16'h0001; // see RULE13
              end
            end
          end
        end
        default: begin
          d.fn = q.fn;
        end
      endcase
    end
    // Line events win over a clear in the same cycle
    if (fault_now) begin
      d.ms_fault = 1'b1; // see RULE1
    end
    if (line_status.idle_error && (d.idle_cnt != phy_mgmt_pkg::IDLE_COUNT_MAX)) begin
      d.idle_cnt = d.idle_cnt + 8'h01; // see RULE6
    end
  end

  // Single state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= phy_mgmt_pkg::MGMT_RESET;
    end else begin
      q <= d;
    end
  end

  // Checks on the bank
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // A read of the address/data register in a given function
  sequence s_data_read(phy_mgmt_pkg::access_fn_t f);
    rd_commit && hdr[4:0] == phy_mgmt_pkg::REG_ADDR_DATA && target_device_address_ok && q.fn == f;
  endsequence
  sequence s_data_write(phy_mgmt_pkg::access_fn_t f);
    wr_commit && q.reg_a == phy_mgmt_pkg::REG_ADDR_DATA && target_device_address_ok && q.fn == f;
  endsequence
  sequence s_status_read;
    rd_commit && hdr[4:0] == phy_mgmt_pkg::REG_LINK_STATUS;
  endsequence

  a_fault_sticky: assert property (q.ms_fault // see RULE1
      && !(rd_commit && hdr[4:0] == phy_mgmt_pkg::REG_LINK_STATUS) |=> q.ms_fault)
    else $error("fault flag dropped without a read");
  a_fault_set: assert property (fault_now |=> q.ms_fault) // see RULE1
    else $error("fault flag not set on conflict");
  a_status_word: assert property (s_status_read // see RULE5 RULE7
      |=> ({q.sh[14:10], 3'b000} == ($past(line_status) & 8'hf8)) && (q.sh[9:8] == 2'b00))
    else $error("status word bits 14:8 wrong");
  a_idle_clear: assert property (s_status_read ##0 !line_status.idle_error
      |=> q.idle_cnt == 8'h00 ##1 (q.idle_cnt <= 8'h01)) // see RULE6
    else $error("idle counter not cleared by read");
  a_ptr_load: assert property (s_data_write(phy_mgmt_pkg::FN_ADDRESS) |=> q.ptr == $past(wr_word)) // see RULE9
    else $error("pointer not loaded");
  a_ptr_hold: assert property (s_data_write(phy_mgmt_pkg::FN_DATA)
      or s_data_read(phy_mgmt_pkg::FN_DATA) |=> $stable(q.ptr)) // see RULE11
    else $error("pointer moved without increment");
  a_ptr_inc_rw: assert property (s_data_read(phy_mgmt_pkg::FN_DATA_INC_RW)
      or s_data_write(phy_mgmt_pkg::FN_DATA_INC_RW) |=> q.ptr == $past(q.ptr) + 16'h0001) // see RULE12
    else $error("pointer not incremented");
  a_ptr_wonly: assert property (s_data_read(phy_mgmt_pkg::FN_DATA_INC_W) |=> $stable(q.ptr)) // see RULE13
    else $error("pointer moved on read in write-increment mode");
  a_target_device_address_gate: assert property (wr_commit && q.reg_a == phy_mgmt_pkg::REG_ADDR_DATA && !target_device_address_ok
      |-> !ext_we ##1 $stable(q.ptr)) // see RULE14
    else $error("access acted with foreign device address");
  a_ctrl_reserved: assert property (rd_commit && hdr[4:0] == phy_mgmt_pkg::REG_ACCESS_CTRL
      |=> q.sh[13:5] == 9'h000) // see RULE16
    else $error("control reserved bits not zero");
  a_ability_fixed: assert property (rd_commit && hdr[4:0] == phy_mgmt_pkg::REG_LOCAL_ABILITY
      |=> q.sh == phy_mgmt_pkg::ABILITY_VALUE) // see RULE17
    else $error("ability word wrong");
  a_unmapped_zero: assert property (rd_commit && hdr[4:0] == phy_mgmt_pkg::REG_ADDR_DATA
      && target_device_address_ok && is_data_fn(q.fn) && !ext_rd_hit |=> q.sh == 16'h0000) // see RULE19
    else $error("unimplemented extended read not zero");
  a_turn_drive: assert property (q.st == phy_mgmt_pkg::ST_TURN && q.cnt == 6'd0 && rise && q.op_read
      |=> mdio_oe && !mdio_o ##1 mdio_oe) // see RULE8
    else $error("turnaround not driven low");

  // Counting, config readback, stored words and release of the line
  a_fault_clear: assert property (s_status_read ##0 !fault_now |=> !q.ms_fault) // see RULE1
    else $error("fault flag not cleared by read");
  a_idle_count: assert property (line_status.idle_error && !rd_commit // see RULE6
      && q.idle_cnt != phy_mgmt_pkg::IDLE_COUNT_MAX |=> q.idle_cnt == $past(q.idle_cnt) + 8'h01)
    else $error("idle error not counted");
  a_config_word: assert property (rd_commit // see RULE18
      && hdr[4:0] == phy_mgmt_pkg::REG_GIG_CONFIG
      |=> q.sh == {3'b000, $past(q.manual_en), $past(q.manual_master), 11'h000})
    else $error("config word wrong");
  a_ext_write: assert property (s_data_write(phy_mgmt_pkg::FN_DATA) ##0 ext_rd_hit // see RULE11
      |=> ext_rd_data == $past(wr_word))
    else $error("extended word not stored");
  a_ptr_winc: assert property (s_data_write(phy_mgmt_pkg::FN_DATA_INC_W) // see RULE13
      |=> q.ptr == $past(q.ptr) + 16'h0001)
    else $error("pointer not incremented after write");
  a_read_release: assert property (q.st == phy_mgmt_pkg::ST_READ_DATA // see RULE8
      && q.cnt == phy_mgmt_pkg::DATA_LAST && rise |=> !mdio_oe)
    else $error("data line not released after read");

endmodule : phy_gig_mgmt_regs

// ### verilog/phy_mgmt_pkg.sv
// Constants, types and state layout for the gigabit management register bank.
// Assumes a single 10 MHz clock and a management serial link sampled as plain pins.
// Function
// RULE1: Fault bit 15 latches high, clears on read
// RULE2: Bit 14 shows resolved master, else slave
// RULE3: Bit 13 shows local receiver OK
// RULE4: Bit 12 shows remote receiver OK
// RULE5: Bits 11/10 show partner gigabit full/half duplex
// RULE6: Bits 7:0 idle error count, clear on read
// RULE7: Reserved status and ability bits read zero
// RULE8: Extended registers reached only through 0x0D/0x0E
// RULE9: Function 00 write loads the address pointer
// RULE10: Software loads pointer before any data access
// RULE11: Function 01 accesses data, pointer unchanged
// RULE12: Function 10 increments pointer after reads, writes
// RULE13: Function 11 increments pointer after writes only
// RULE14: Indirect access acts only with device address 11111
// RULE15: Software writes 0x1F into device address first
// RULE16: Control bits 13:5 read zero; fields reset zero
// RULE17: Ability register fixed: 15,14 zero; 13,12 one
// RULE18: Config bits 12/11 enable and choose manual role
// RULE19: Unimplemented extended address reads zero, ignores writes
package phy_mgmt_pkg;

  // Register addresses on the management link
  localparam logic [4:0] REG_GIG_CONFIG = 5'h09;
  localparam logic [4:0] REG_LINK_STATUS = 5'h0a;
  localparam logic [4:0] REG_ACCESS_CTRL = 5'h0d;
  localparam logic [4:0] REG_ADDR_DATA = 5'h0e;
  localparam logic [4:0] REG_LOCAL_ABILITY = 5'h0f;

  // Extended space starts above this address
  localparam logic [15:0] EXT_LOW_LIMIT = 16'h001f;
  localparam logic [15:0] EXT_BASE = 16'h0020;
  localparam int EXT_DEPTH = 8;

  // Field positions
  localparam int CFG_MANUAL_EN_BIT = 12;
  localparam int CFG_MANUAL_VAL_BIT = 11;
  localparam int CTRL_FN_LSB = 14;
  localparam int STS_FAULT_BIT = 15;

  // Fixed values
  localparam logic [4:0] VENDOR_DEVICE_ADDR = 5'h1f;
  localparam logic [15:0] ABILITY_VALUE = 16'h3000;
  localparam logic [7:0] IDLE_COUNT_MAX = 8'hff;

  // Serial frame layout, counted in management clock edges
  localparam logic [5:0] PREAMBLE_BITS = 6'd32;
  localparam logic [5:0] HEADER_LAST = 6'd13;
  localparam logic [5:0] DATA_LAST = 6'd15;
  localparam logic [1:0] FRAME_START = 2'b01;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;

  // Indirect access function field
  typedef enum logic [1:0] {
    FN_ADDRESS = 2'b00,
    FN_DATA = 2'b01,
    FN_DATA_INC_RW = 2'b10,
    FN_DATA_INC_W = 2'b11
  } access_fn_t;

  // Serial frame states
  typedef enum logic [2:0] {
    ST_PREAMBLE = 3'b000,
    ST_HEADER = 3'b001,
    ST_TURN = 3'b010,
    ST_READ_DATA = 3'b011,
    ST_WRITE_DATA = 3'b100
  } frame_st_t;

  // Line-side status carried into the bank
  typedef struct packed {
    logic resolved_master;
    logic local_rx_ok;
    logic remote_rx_ok;
    logic partner_full_duplex;
    logic partner_half_duplex;
    logic partner_manual_en;
    logic partner_manual_master;
    logic idle_error;
  } line_status_t;

  // Whole state of the bank
  typedef struct packed {
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_prev;
    logic mdio_s1;
    logic mdio_s2;
    frame_st_t st;
    logic [5:0] cnt;
    logic [15:0] sh;
    logic op_read;
    logic [4:0] reg_a;
    logic drv_o;
    logic drv_oe;
    access_fn_t fn;
    logic [4:0] target_device_address;
    logic [15:0] ptr;
    logic manual_en;
    logic manual_master;
    logic ms_fault;
    logic [7:0] idle_cnt;
  } mgmt_state_t;

  localparam mgmt_state_t MGMT_RESET = '0;

endpackage : phy_mgmt_pkg
